//--- design/imst_pkg.sv
// Constants, register map and state type for the audio serial bus master.
// Assumes a single 25 MHz reference clock with a synchronous active-high reset.
package imst_pkg;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BCLK_HZ = 1_536_000;
    localparam int MCLK_HZ = 12_000_000;
    localparam int BCLK_HALF_CYC = (CLK_HZ / (2 * BCLK_HZ)) < 1 ? 1 : CLK_HZ / (2 * BCLK_HZ);
    localparam int MCLK_HALF_CYC = (CLK_HZ / (2 * MCLK_HZ)) < 1 ? 1 : CLK_HZ / (2 * MCLK_HZ);
    localparam int SLOT_BITS = 32;
    localparam logic [4:0] HALF_SLOT = 5'h10;
    localparam logic [4:0] LOAD_POS = 5'h01;
    localparam logic [4:0] LAST_BIT = 5'h1f;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_TX_DATA = 8'h08;
    localparam logic [7:0] OFS_RX_DATA = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // transmit_shifter_control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DMA_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_POL_BIT = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
    localparam logic [2:0] MODE_TX = 3'h2;

    // transmit_shifter_config fields
    localparam int CFG_START_BIT = 0;
    localparam int CFG_STOP_LSB = 4;
    localparam int CFG_INPUT_SOURCE_SELECT_BIT = 8;
    localparam logic [31:0] CFG_RST = 32'h0000_0001;
    localparam logic [31:0] CFG_MASK = 32'h0000_0131;

    // Status fields
    localparam int ST_TXE_BIT = 0;
    localparam int ST_RXF_BIT = 1;
    localparam int ST_ERR_BIT = 2;
    localparam int ST_RUN_BIT = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b10
    } imst_state_t;
endpackage

//--- design/imst_clkdiv.sv
// Timer that divides the reference clock by an even count.
// Assumes the run input gates it; output idles low while stopped.
`timescale 1ns/1ps
`default_nettype none
module imst_clkdiv #(
    parameter int HALF = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic run,
    // Timer output and edge lookahead
    output logic clk_out,
    output logic rise,
    output logic fall
);
    localparam int CW = $clog2(HALF + 1);
    logic [CW-1:0] cnt;
    logic wrap;

    assign wrap = run && (cnt == CW'(HALF - 1));
    // Edge pulses lead the toggle so users act on the same clock edge
    assign rise = wrap && !clk_out;
    assign fall = wrap && clk_out;

    // Period is 2*HALF reference cycles, always even
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt <= '0;
            clk_out <= 1'b0;
        end else if (wrap) begin
            cnt <= '0;
            clk_out <= !clk_out;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- design/imst_top.sv
// Audio serial bus master: bit clock, frame sync, master clock, tx and rx shifters.
// Assumes a classic Wishbone master and a codec acting as serial audio slave.
//
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module imst_top import imst_pkg::*; #(
    parameter int BCLK_HALF = BCLK_HALF_CYC,
    parameter int MCLK_HALF = MCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // DMA requests
    output logic dma_tx_req,
    output logic dma_rx_req,
    // Serial audio pins
    output logic master_clock,
    output logic bit_clock,
    output logic frame_sync,
    output logic serial_tx,
    input wire logic serial_rx
);
    logic [31:0] ctrl;
    logic [31:0] cfg;
    imst_state_t state;
    logic running;
    logic bclk_rise;
    logic bclk_fall;
    logic mclk_pin;
    logic bclk_pin;
    logic first_edge;
    logic [4:0] slot_cnt;
    logic [4:0] next_slot_cnt;
    logic [31:0] tx_buf;
    logic tx_full;
    logic [31:0] tx_sr;
    logic load_evt;
    logic rx_on;
    logic [4:0] rx_bits;
    logic [31:0] rx_sr;
    logic [31:0] rx_buf;
    logic rx_full;
    logic rx_store;
    logic rx_in;
    logic err_flag;
    logic wb_hit;
    logic wb_wr;
    logic tx_wr;
    logic rx_rd;
    logic err_clr;
    logic ctrl_en;
    logic tx_mode;
    logic tx_pol;

    function automatic logic [31:0] imst_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_hit && wb_we_i;
    assign tx_wr = wb_wr && (wb_adr_i == OFS_TX_DATA);
    assign rx_rd = wb_hit && !wb_we_i && (wb_adr_i == OFS_RX_DATA);
    assign err_clr = wb_wr && (wb_adr_i == OFS_STATUS) && wb_sel_i[0] && wb_dat_i[ST_ERR_BIT];
    assign ctrl_en = ctrl[CTRL_EN_BIT];
    assign tx_mode = ctrl[CTRL_MODE_LSB +: 3] == MODE_TX;
    assign tx_pol = ctrl[CTRL_POL_BIT];
    assign running = state == ST_RUN;
    // Config input source: pin, or the transmit output as loopback
    assign rx_in = cfg[CFG_INPUT_SOURCE_SELECT_BIT] ? serial_tx : serial_rx;

    // Wishbone: answer one cycle after the request, ack drops next cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    OFS_CTRL: wb_dat_o <= ctrl;
                    OFS_CFG: wb_dat_o <= cfg;
                    OFS_RX_DATA: wb_dat_o <= rx_buf;
                    OFS_STATUS: wb_dat_o <= {28'h0000000, running, err_flag, rx_full, !tx_full};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl <= CTRL_RST;
            cfg <= CFG_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == OFS_CTRL) begin
                ctrl <= imst_merge(ctrl, wb_dat_i, wb_sel_i, CTRL_MASK);
            end
            if (wb_adr_i == OFS_CFG) begin
                cfg <= imst_merge(cfg, wb_dat_i, wb_sel_i, CFG_MASK);
            end
        end
    end

    // Bit clock and frame sync wait in ARMED until the first transmit buffer write
    always_ff @(posedge ref_clk) begin
        if (srst || !ctrl_en) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= ST_ARMED;
                ST_ARMED: begin
                    if (tx_wr) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: state <= ST_RUN;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Timer 0: bit clock, also the only source of shifter events
    imst_clkdiv #(
        .HALF(BCLK_HALF)
    ) u_bclk (
        .clk(ref_clk),
        .srst(srst),
        .run(running),
        .clk_out(bclk_pin),
        .rise(bclk_rise),
        .fall(bclk_fall)
    );

    // Timer 2: master clock, free running while enabled, third timer
    imst_clkdiv #(
        .HALF(MCLK_HALF)
    ) u_mclk (
        .clk(ref_clk),
        .srst(srst),
        .run(ctrl_en),
        .clk_out(mclk_pin),
        .rise(),
        .fall()
    );

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            master_clock <= 1'b0;
            bit_clock <= 1'b0;
        end else begin
            master_clock <= mclk_pin;
            // Next timer level, so bit clock moves with frame sync
            bit_clock <= running && (bclk_pin ^ (bclk_rise || bclk_fall));
        end
    end

    // Start bit puts the first slot position one bit ahead of data
    always_comb begin
        if (first_edge) begin
            next_slot_cnt = cfg[CFG_START_BIT] ? 5'h00 : LOAD_POS;
        end else begin
            next_slot_cnt = slot_cnt + 5'h01;
        end
    end

    assign load_evt = running && bclk_rise && (next_slot_cnt == LOAD_POS);

    // Slot counter and frame sync (timer 1), active low left half
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            first_edge <= 1'b1;
            slot_cnt <= 5'h00;
            frame_sync <= 1'b1;
        end else if (bclk_rise) begin
            first_edge <= 1'b0;
            slot_cnt <= next_slot_cnt;
            frame_sync <= next_slot_cnt >= HALF_SLOT;
        end
    end

    // Transmit shifter: change on shift-clock rise, MSB first
    always_ff @(posedge ref_clk) begin
        if (srst || !running || !tx_mode) begin
            tx_sr <= 32'h0000_0000;
            serial_tx <= tx_pol;
        end else if (load_evt) begin
            tx_sr <= tx_full ? tx_buf : 32'h0000_0000;
            serial_tx <= (tx_full && tx_buf[SLOT_BITS-1]) ^ tx_pol;
        end else if (bclk_rise) begin
            tx_sr <= tx_sr << 1;
            serial_tx <= tx_sr[SLOT_BITS-2] ^ tx_pol;
        end
    end

    // Transmit buffer: a write in the load cycle wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_buf <= 32'h0000_0000;
            tx_full <= 1'b0;
        end else if (tx_wr) begin
            tx_buf <= wb_dat_i;
            tx_full <= 1'b1;
        end else if (load_evt && tx_mode) begin
            tx_full <= 1'b0;
        end
    end

    assign rx_store = running && bclk_fall && rx_on && (rx_bits == LAST_BIT);

    // Receive shifter: sample on shift-clock fall, aligned to first load
    always_ff @(posedge ref_clk) begin
        if (srst || !running) begin
            rx_on <= 1'b0;
            rx_bits <= 5'h00;
            rx_sr <= 32'h0000_0000;
        end else begin
            if (load_evt) begin
                rx_on <= 1'b1;
            end
            if (bclk_fall && rx_on) begin
                rx_sr <= {rx_sr[SLOT_BITS-2:0], rx_in};
                rx_bits <= rx_bits + 5'h01;
            end
        end
    end

    // Receive buffer: a store in the read cycle wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_buf <= 32'h0000_0000;
            rx_full <= 1'b0;
        end else if (rx_store) begin
            rx_buf <= {rx_sr[SLOT_BITS-2:0], rx_in};
            rx_full <= 1'b1;
        end else if (rx_rd) begin
            rx_full <= 1'b0;
        end
    end

    // Sticky error, write one to clear; a new event wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            err_flag <= 1'b0;
        end else if ((load_evt && tx_mode && !tx_full) || (rx_store && rx_full && !rx_rd)) begin
            err_flag <= 1'b1;
        end else if (err_clr) begin
            err_flag <= 1'b0;
        end
    end

    // DMA requests as alternative to processor polling
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dma_tx_req <= 1'b0;
            dma_rx_req <= 1'b0;
        end else begin
            dma_tx_req <= ctrl[CTRL_DMA_BIT] && ctrl_en && tx_mode && !tx_full && !tx_wr;
            dma_rx_req <= ctrl[CTRL_DMA_BIT] && ctrl_en && rx_full && !rx_rd;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    logic [7:0] mclk_stall;
    always_ff @(posedge ref_clk) begin
        if (srst || !ctrl_en || (mclk_pin != master_clock)) begin
            mclk_stall <= 8'h00;
        end else if (mclk_stall != 8'hff) begin
            mclk_stall <= mclk_stall + 8'h01;
        end
    end

    chk_idle_no_clocks: assert property (
        !$past(running) && !$past(running, 2) |-> !bit_clock && frame_sync)
        else $error("bit clock or frame sync active before start");

    chk_fs_first_edge: assert property (
        running && first_edge && bclk_rise |=> !frame_sync && bit_clock)
        else $error("frame sync not asserted with first bit clock edge");

    chk_ws_half_toggle: assert property (
        running && bclk_rise && !first_edge && (next_slot_cnt == HALF_SLOT) |=> frame_sync)
        else $error("word select did not toggle at half slot");

    chk_load_timer: assert property (
        $fell(tx_full) && !$past(tx_wr) |-> $past(bclk_rise) && $past(running))
        else $error("buffer taken outside a bit clock event");

    chk_msb_out: assert property (
        load_evt && tx_mode && tx_full |=> serial_tx == ($past(tx_buf[SLOT_BITS-1]) ^ tx_pol))
        else $error("loaded word MSB not on transmit pin");

    chk_underrun_err: assert property (
        load_evt && tx_mode && !tx_full |=> err_flag)
        else $error("underrun did not set error flag");

    chk_overflow_err: assert property (
        rx_store && rx_full && !rx_rd |=> err_flag && rx_full)
        else $error("overflow did not set error flag");

    chk_rx_store_word: assert property (
        rx_store |=> rx_full && (rx_buf == {$past(rx_sr[SLOT_BITS-2:0]), $past(rx_in)}))
        else $error("received word not stored");

    chk_mclk_runs: assert property (
        mclk_stall <= 8'(MCLK_HALF + 1))
        else $error("master clock stalled while enabled");

    chk_sync_before_data: assert property (
        running && first_edge && bclk_rise && cfg[CFG_START_BIT] |=> serial_tx == tx_pol)
        else $error("data bit driven with the start bit");

    chk_start_wait: assert property (
        (state == ST_ARMED) && !tx_wr |=> !running)
        else $error("clocks started without a transmit write");

    cov_first_frame: cover property (running && first_edge && bclk_rise);
    cov_underrun: cover property (load_evt && tx_mode && !tx_full);
    cov_rx_word: cover property (rx_store);
    cov_overflow: cover property (rx_store && rx_full && !rx_rd);
    cov_half_slot: cover property (running && bclk_rise && (next_slot_cnt == HALF_SLOT));
endmodule
`default_nettype wire

//--- tb/imst_codec_model.sv
// Codec model: serial audio slave that hears tx words and answers with a fixed word.
// Assumes the master moves bit_clock and frame_sync on the same reference edge.
`timescale 1ns/1ps
`default_nettype none
module imst_codec_model import imst_pkg::*; #(
    parameter int HALF = 3,
    parameter logic [31:0] REPLY = 32'h5a3c_96e1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Serial audio pins
    input wire logic bit_clock,
    input wire logic frame_sync,
    input wire logic serial_tx,
    output logic serial_rx,
    // Observations
    output logic [31:0] heard,
    output int words,
    output int bad
);
    logic pb;
    int rises;
    int gap;
    logic [31:0] sh;
    always_ff @(posedge ref_clk) begin
        pb <= bit_clock;
        gap <= gap + 1;
        if (srst) begin
            rises <= 0;
            words <= 0;
            bad <= 0;
            gap <= 0;
            serial_rx <= 1'b0;
            heard <= 32'h0;
        end else if (bit_clock && !pb) begin
            // Period must be an even division of the clock
            if (rises > 0 && gap != 2 * HALF - 1) bad <= bad + 1;
            // Low for the left 16 bits, high for the right 16
            if (frame_sync !== (rises % 32 >= 16)) bad <= bad + 1;
            // Codec drives its word MSB first, one bit per bit clock
            serial_rx <= REPLY[31 - ((rises + 31) % 32)];
            rises <= rises + 1;
            gap <= 0;
        end else if (!bit_clock && pb && rises > 1) begin
            // Rise 0 is the start bit and carries no data
            sh <= {sh[30:0], serial_tx};
            if ((rises - 1) % 32 == 0) begin
                heard <= {sh[30:0], serial_tx};
                words <= words + 1;
            end
        end else if (rises == 0) begin
            // Toggles every reference cycle before the first frame
            serial_rx <= ~serial_rx;
        end
    end
endmodule
`default_nettype wire

//--- tb/imst_top_test.sv
// Self-checking bench for the audio serial bus master.
// Assumes a classic Wishbone master drives registers and the codec model sits on the pins.
`timescale 1ns/1ps
`default_nettype none
module imst_top_test import imst_pkg::*;;
    localparam int BH = 3;
    localparam logic [31:0] REPLY = 32'h5a3c_96e1;
    logic ref_clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, heard;
    logic dma_tx_req, dma_rx_req, master_clock, bit_clock, frame_sync, serial_tx, serial_rx;
    int n_errors = 0, samples_checked = 0, words, bad, seen_words = 0, seed = 99230, n, k;
    logic [31:0] exp_q[$];
    logic [31:0] w[4];
    always #20 ref_clk = ~ref_clk;
    imst_top #(.BCLK_HALF(BH), .MCLK_HALF(1)) dut (.ref_clk(ref_clk), .srst(srst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .master_clock(master_clock),
        .bit_clock(bit_clock), .frame_sync(frame_sync), .serial_tx(serial_tx),
        .serial_rx(serial_rx));
    imst_codec_model #(.HALF(BH), .REPLY(REPLY)) codec (.ref_clk(ref_clk), .srst(srst),
        .bit_clock(bit_clock), .frame_sync(frame_sync), .serial_tx(serial_tx),
        .serial_rx(serial_rx), .heard(heard), .words(words), .bad(bad));
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int c;
        c = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge ref_clk);
            c++;
        end while (wb_ack_o !== 1'b1 && c < 20);
        if (c >= 20) begin
            n_errors++;
            complete_run();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic expect_bit(input bit use_bclk, input int lim);
        int c;
        for (c = 0; c < lim && (use_bclk ? bit_clock : dma_tx_req) !== 1'b1; c++) begin
            @(posedge ref_clk);
        end
        if (c >= lim) begin
            n_errors++;
            complete_run();
        end
    endtask
    // Each finished codec word against the queue of words sent
    always @(posedge ref_clk) begin
        if (words != seen_words) begin
            seen_words = words;
            if (exp_q.size() > 0) check("tx word", heard, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end
    initial begin
        w[0] = 32'h8000_0001;
        w[1] = 32'hffff_ffff;
        w[2] = {16'($random(seed)), 16'h0000}; // Mono 16-bit sample in the slot
        w[3] = $random(seed);
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        wb(0, OFS_CTRL, 0); check("ctrl reset", rd, CTRL_RST);
        wb(0, OFS_CFG, 0); check("cfg reset", rd, CFG_RST);
        wb(0, 8'h20, 0); check("unmapped", rd, 32'h0);
        wb(1, OFS_CFG, 32'hffff_ffff);
        wb(0, OFS_CFG, 0); check("cfg mask", rd, CFG_MASK);
        wb(1, OFS_CFG, CFG_RST);
        wb(1, OFS_CTRL, 32'h0000_000b);
        n = 0;
        k = 0;
        repeat (20) begin
            @(posedge ref_clk);
            n += (master_clock !== rd[0]);
            k += (bit_clock !== 1'b0);
            rd[0] = master_clock;
        end
        check("mclk toggles", n, 32'd19);
        check("bclk held", k, 32'd0);
        check("dma tx idle", dma_tx_req, 1'b1);
        wb(0, OFS_STATUS, 0); check("status idle", rd, 32'h1);
        for (int i = 0; i < 4; i++) begin
            expect_bit(1'b0, 400);
            wb(1, OFS_TX_DATA, w[i]);
            exp_q.push_back(w[i]);
            if (i == 0) begin
                expect_bit(1'b1, 20);
                check("first sync", frame_sync, 1'b0);
            end
            check("dma rx", dma_rx_req, i >= 2);
            if (dma_rx_req === 1'b1) begin
                wb(0, OFS_RX_DATA, 0); check("rx word", rd, REPLY);
            end
        end
        wb(0, OFS_STATUS, 0); check("no error", rd[ST_ERR_BIT], 1'b0);
        exp_q.push_back(32'h0);
        for (n = 0; n < 200 && rd[ST_ERR_BIT] !== 1'b1; n++) wb(0, OFS_STATUS, 0);
        check("underrun", rd[ST_ERR_BIT], 1'b1);
        check("rx full", rd[ST_RXF_BIT], 1'b1);
        // Let the underrun word reach the codec before stopping
        for (n = 0; n < 400 && words < 5; n++) begin
            @(posedge ref_clk);
        end
        wb(1, OFS_CTRL, 32'h0000_0008);
        wb(1, OFS_STATUS, 32'h4);
        wb(0, OFS_STATUS, 0); check("error cleared", rd[ST_ERR_BIT], 1'b0);
        check("bclk stopped", bit_clock, 1'b0);
        check("words heard", words, 32'd5);
        check("codec view", bad, 32'd0);
        complete_run();
    end
endmodule
`default_nettype wire
